// File: rtl/irq_vec_cfg.svh
// constants for the interrupt vector priority block
`ifndef IRQ_VEC_CFG_SVH
`define IRQ_VEC_CFG_SVH
`define VEC_COUNT 64
`define VEC_TOP_ADDR 16'hfffe
`define VEC_GAP_LO 6'h20
`define VEC_GAP_HI 6'h2f
`define VEC_LAST 6'h37
`define VEC_RESTART 6'h00
`define VEC_TRAP 6'h01
`define VEC_PORT_PINS 6'h16
`define VEC_SLOT_BYTES 16'h0002
`endif

// File: rtl/irq_vec_pkg.sv
// types for the interrupt vector priority block
package irq_vec_pkg;
  // reset causes served by the restart vector
  typedef struct packed {
    logic watchdog_cause;
    logic clock_loss_cause;
    logic low_voltage_cause;
    logic pin_cause;
    logic bad_opcode_cause;
    logic bad_address_cause;
    logic power_on_cause;
    logic debugger_forced_cause;
  } reset_causes_t;
  // the three pin-interrupt flag/enable pairs sharing one vector
  typedef struct packed {
    logic port_a_pin_flag;
    logic port_b_pin_flag;
    logic port_d_pin_flag;
    logic port_a_pin_enable;
    logic port_b_pin_enable;
    logic port_d_pin_enable;
  } port_pins_t;
  // selected vector toward the core
  typedef struct packed {
    logic valid;
    logic [5:0] number;
    logic [15:0] addr_high;
    logic [15:0] addr_low;
  } vec_sel_t;
  typedef enum logic [1:0] {FETCH_IDLE, FETCH_HIGH, FETCH_LOW} fetch_state_t;
endpackage

// File: rtl/irq_vec_prio.sv
// interrupt request qualification, priority encoding and vector fetch
`include "irq_vec_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module irq_vec_prio (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // peripheral sources: one flag and one enable per vector, three pin pairs on one vector, reset causes and trap without enables
  input wire logic [63:0] src_flag,
  input wire logic [63:0] src_enable,
  input wire irq_vec_pkg::port_pins_t port_pins,
  input wire irq_vec_pkg::reset_causes_t reset_causes,
  input wire logic trap_request,
  // core side
  input wire logic global_mask,
  input wire logic vector_fetch,
  input wire logic [7:0] mem_rdata,
  output logic irq_request,
  output irq_vec_pkg::vec_sel_t vec_sel,
  output logic [15:0] mem_addr,
  output logic mem_read,
  output logic [15:0] service_addr,
  output logic service_valid
);

  // slot address of a vector number
  // two bytes per slot, growing down from the restart slot at the top
  // used for both the high and the low byte address of the selection, so kept in one place
  function automatic logic [15:0] slot_addr(input logic [5:0] n);
    slot_addr = `VEC_TOP_ADDR - (`VEC_SLOT_BYTES * {10'h000, n});
  endfunction

  // vector numbers that may carry a request
  // the hole in the middle is not vector space at all, the top eight
  // numbers are unassigned; neither may ever win
  function automatic logic implemented(input logic [5:0] n);
    logic in_gap;
    in_gap = (n >= `VEC_GAP_LO) && (n <= `VEC_GAP_HI);
    if (n > `VEC_LAST) begin
      implemented = 1'b0;
    end else if (in_gap) begin
      implemented = 1'b0;
    end else begin
      implemented = 1'b1;
    end
  endfunction

  // gated requests, one bit per vector number
  logic [63:0] req_vec;

  // shared sources folded into their single vector
  logic any_reset;
  logic port_req;

  // arbitration result and its register
  irq_vec_pkg::vec_sel_t sel_next;
  irq_vec_pkg::vec_sel_t sel_reg;

  // maskable request toward the core
  logic irq_next;
  logic irq_reg;

  // request qualification
  // restart, trap and port bits of src_flag are overwritten here, so a
  // stray flag on those numbers cannot raise a request of its own
  always_comb begin
    any_reset = |reset_causes;
    port_req = (port_pins.port_a_pin_flag & port_pins.port_a_pin_enable)
             | (port_pins.port_b_pin_flag & port_pins.port_b_pin_enable)
             | (port_pins.port_d_pin_flag & port_pins.port_d_pin_enable);
    req_vec = src_flag & src_enable;
    req_vec[`VEC_RESTART] = any_reset;
    req_vec[`VEC_TRAP] = trap_request;
    req_vec[`VEC_PORT_PINS] = port_req;
    for (int i = 0; i < `VEC_COUNT; i++) begin
      if (!implemented(6'(i))) begin
        req_vec[i] = 1'b0;
      end
    end
  end

  // fixed priority encoder, re-evaluated every cycle
  // scanned from the top down: the lowest requesting number is written
  // last and wins, so a newly raised higher request takes over next cycle
  always_comb begin
    sel_next = '0;
    for (int i = `VEC_COUNT - 1; i >= 0; i--) begin
      if (req_vec[i]) begin
        sel_next.valid = 1'b1;
        sel_next.number = 6'(i);
      end
    end
    sel_next.addr_high = slot_addr(sel_next.number);
    sel_next.addr_low = slot_addr(sel_next.number) + 16'h0001;
    irq_next = sel_next.valid & (sel_next.number != `VEC_RESTART) & (sel_next.number != `VEC_TRAP);
  end

  // registered arbitration result
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      irq_reg <= irq_next;
    end
  end

  // fetch sequencer state
  irq_vec_pkg::fetch_state_t state_reg;
  irq_vec_pkg::fetch_state_t state_next;

  // address of the byte being read
  logic [15:0] addr_reg;
  logic [15:0] addr_next;

  // high byte held until the low byte arrives
  logic [7:0] high_reg;
  logic [7:0] high_next;

  // assembled service address and its one-cycle strobe
  logic [15:0] svc_reg;
  logic [15:0] svc_next;
  logic svc_valid_reg;
  logic svc_valid_next;

  // one-cycle read strobe per byte
  logic read_reg;
  logic read_next;

  // two-byte vector fetch, high byte first
  // the vector number is fixed when the fetch starts; a later, higher
  // request waits for the next fetch rather than mixing two slots
  // memory is zero-wait: data stands in the cycle the read strobe is high
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    high_next = high_reg;
    svc_next = svc_reg;
    svc_valid_next = 1'b0;
    read_next = 1'b0;
    case (state_reg)
      irq_vec_pkg::FETCH_IDLE: begin
        if (vector_fetch && sel_reg.valid) begin
          addr_next = sel_reg.addr_high;
          read_next = 1'b1;
          state_next = irq_vec_pkg::FETCH_HIGH;
        end
      end

      irq_vec_pkg::FETCH_HIGH: begin
        high_next = mem_rdata;
        addr_next = addr_reg + 16'h0001;
        read_next = 1'b1;
        state_next = irq_vec_pkg::FETCH_LOW;
      end

      irq_vec_pkg::FETCH_LOW: begin
        svc_next = {high_reg, mem_rdata};
        svc_valid_next = 1'b1;
        state_next = irq_vec_pkg::FETCH_IDLE;
      end

      default: begin
        state_next = irq_vec_pkg::FETCH_IDLE;
      end
    endcase
  end

  // fetch registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= irq_vec_pkg::FETCH_IDLE;
      addr_reg <= 16'h0000;
      high_reg <= 8'h00;
      svc_reg <= 16'h0000;
      svc_valid_reg <= 1'b0;
      read_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      high_reg <= high_next;
      svc_reg <= svc_next;
      svc_valid_reg <= svc_valid_next;
      read_reg <= read_next;
    end
  end

  // outputs straight from flip-flops
  assign irq_request = irq_reg;
  assign vec_sel = sel_reg;
  assign mem_addr = addr_reg;
  assign mem_read = read_reg;
  assign service_addr = svc_reg;
  assign service_valid = svc_valid_reg;

  // global_mask is held by the core, which gates its own acceptance;
  // the block keeps forwarding requests whatever the mask says, so the
  // highest pending one is ready the moment the mask clears
  logic unused_mask;
  assign unused_mask = global_mask;

endmodule
`default_nettype wire

// File: verif/interrupt_vector_priority_bench.sv
// self-checking bench for the vector priority block
`timescale 1ns/100ps
`default_nettype none
module interrupt_vector_priority_bench;
  logic mclk, rst_n, trap_request, vector_fetch, irq_request, mem_read, service_valid, global_mask;
  logic [63:0] src_flag, src_enable;
  logic [15:0] mem_addr, service_addr;
  logic [7:0] mem_rdata;
  irq_vec_pkg::port_pins_t port_pins;
  irq_vec_pkg::reset_causes_t reset_causes;
  irq_vec_pkg::vec_sel_t vec_sel;
  int n_mismatch = 0;
  int num_checks = 0;
  // rows: source a, source b, b enabled, winner
  logic [5:0] ra[4] = '{6'h09, 6'h0c, 6'h32, 6'h37};
  logic [5:0] rb[4] = '{6'h05, 6'h03, 6'h28, 6'h1f};
  logic [3:0] re = 4'b1101;
  logic [5:0] rx[4] = '{6'h05, 6'h0c, 6'h32, 6'h1f};
  irq_vec_prio DUT (.mclk, .rst_n, .src_flag, .src_enable, .port_pins, .reset_causes, .trap_request,
    .global_mask, .vector_fetch, .mem_rdata, .irq_request, .vec_sel, .mem_addr, .mem_read,
    .service_addr, .service_valid);
  vec_rom ROM (.mem_addr, .mem_read, .mem_rdata);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // settle, request the vector, check the assembled address
  task automatic fetch(input logic [5:0] n);
    logic [15:0] a;
    a = 16'hfffe - {9'h0, n, 1'b0};
    @(negedge mclk);
    chk({15'h0, irq_request}, {15'h0, n > 6'h01});
    vector_fetch = 1'b1;
    @(negedge mclk);
    vector_fetch = 1'b0;
    for (int i = 0; i < 8 && service_valid !== 1'b1; i++) @(negedge mclk);
    if (service_valid !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    chk(service_addr, {a[7:0] ^ 8'h3c, (a[7:0] + 8'h01) ^ 8'h3c});
  endtask
  initial begin
    {rst_n, trap_request, vector_fetch, src_flag, src_enable, port_pins, reset_causes} = '0;
    global_mask = 1'b0;
    repeat (20) @(negedge mclk);
    chk({13'h0, irq_request, mem_read, vec_sel.valid}, 16'h0);
    rst_n = 1'b1;
    foreach (ra[i]) begin
      src_flag = (64'h1 << ra[i]) | (64'h1 << rb[i]);
      src_enable = (64'h1 << ra[i]) | ({63'h0, re[i]} << rb[i]);
      fetch(rx[i]);
    end
    // shared port vector, one pin pair at a time
    src_flag = '0;
    for (int i = 0; i < 3; i++) begin
      port_pins = 6'h09 << i;
      fetch(6'h16);
    end
    // flags without enables stay quiet
    port_pins = 6'h38;
    repeat (2) @(negedge mclk);
    chk({15'h0, vec_sel.valid}, 16'h0);
    // trap over port pins, then every restart cause
    port_pins = 6'h3f;
    trap_request = 1'b1;
    fetch(6'h01);
    for (int i = 0; i < 8; i++) begin
      reset_causes = 8'h01 << i;
      fetch(6'h00);
    end
    wrap_up();
  end
endmodule
`default_nettype wire

// File: verif/vec_chk_sva.sv
// assertions on the vector priority block ports
`timescale 1ns/100ps
`default_nettype none
module vec_chk (
  // inputs
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [63:0] src_flag,
  input wire logic [63:0] src_enable,
  input wire irq_vec_pkg::port_pins_t port_pins,
  input wire irq_vec_pkg::reset_causes_t reset_causes,
  // outputs
  input wire irq_vec_pkg::vec_sel_t vec_sel,
  input wire logic [15:0] mem_addr,
  input wire logic mem_read,
  input wire logic service_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // selection
  a_restart_wins: assert property (|reset_causes |=> vec_sel.valid && vec_sel.number == 6'h00)
    else $error("restart lost");
  a_enable_gate: assert property (src_enable == 0 && port_pins == 0 && reset_causes == 0 |=>
    !vec_sel.valid || vec_sel.number == 6'h01) else $error("ungated");
  a_held_wins: assert property (src_flag[9] && src_enable[9] |=> vec_sel.valid && vec_sel.number <= 6'h09)
    else $error("held lost");
  a_port_share: assert property (port_pins[3] && port_pins[0] |=> vec_sel.valid && vec_sel.number <= 6'h16)
    else $error("port lost");
  a_slot_addr: assert property (vec_sel.valid |-> vec_sel.addr_low == vec_sel.addr_high + 16'h0001 &&
    vec_sel.addr_high == 16'hfffe - {9'h0, vec_sel.number, 1'b0}) else $error("slot");
  a_no_gap: assert property (vec_sel.valid |-> !(vec_sel.number inside {[6'h20:6'h2f], [6'h38:6'h3f]}))
    else $error("gap");
  // fetch
  a_byte_walk: assert property ($rose(mem_read) |-> !mem_addr[0] ##1 mem_read ##1 service_valid)
    else $error("walk");
  a_read_range: assert property (mem_read |-> mem_addr >= 16'hff90 && !(mem_addr inside {[16'hffa0:16'hffbf]}))
    else $error("range");
  c_fetch: cover property (service_valid);
  c_restart: cover property (vec_sel.valid && vec_sel.number == 6'h00);
  c_port: cover property (vec_sel.number == 6'h16 && service_valid);
endmodule
bind irq_vec_prio vec_chk u_chk (.mclk, .rst_n, .src_flag, .src_enable, .port_pins, .reset_causes, .vec_sel,
  .mem_addr, .mem_read, .service_valid);
`default_nettype wire

// File: verif/vec_rom.sv
// vector table memory that answers fetch reads
`timescale 1ns/100ps
`default_nettype none
module vec_rom (
  // fetch side
  input wire logic [15:0] mem_addr,
  input wire logic mem_read,
  // data
  output logic [7:0] mem_rdata
);
  // scrambled address byte, inverted when not read
  assign mem_rdata = mem_addr[7:0] ^ 8'h3c ^ {8{!mem_read}};
endmodule
`default_nettype wire
